// ==== rtl/eecfg_defines.svh ====
`ifndef EECFG_DEFINES_SVH
`define EECFG_DEFINES_SVH

// header layout
`define EECFG_HDR_ADDR        8'h00
`define EECFG_HDR_RSVD_ADDR   8'h01
`define EECFG_BURST_ADDR      8'h02
`define EECFG_SLOT_BASE       8'h03
`define EECFG_HDR_CRC_BIT     7
`define EECFG_HDR_MAP_BIT     6
`define EECFG_HDR_LARGE_BIT   5
`define EECFG_HDR_CNT_MSB     3
// device block layout
`define EECFG_BLK_FIRST       8'h03
`define EECFG_BLK_LAST        8'h27
`define EECFG_BLK_LEN         8'h25
`define EECFG_BLK_LOS_OFS     8'h00
`define EECFG_BLK_CTL_OFS     8'h01
`define EECFG_BLK_SWING_OFS   8'h15
`define EECFG_LOS_SEL_BIT     2
`define EECFG_SIGNAL_LOSS_OVERRIDE_BIT    7
`define EECFG_LOS_VAL_BIT     6
`define EECFG_INPUT_POWERDOWN_BIT    5
`define EECFG_OSCILLATOR_POWERDOWN_BIT    4
`define EECFG_SATA_A_BIT      2
`define EECFG_SATA_B_BIT      1
`define EECFG_TXDIS_BIT       0
`define EECFG_SWING_MSB       5
`define EECFG_SWING_LSB       3
`define EECFG_SWING_RST       3'h3
// wishbone register offsets
`define EECFG_REG_CTRL        8'h00
`define EECFG_REG_STATUS      8'h04
`define EECFG_REG_HEADER      8'h08
`define EECFG_REG_CONFIG      8'h0C
`define EECFG_REG_DATA        8'h10
`define EECFG_REG_SLOT        8'h14

`endif

// ==== rtl/eecfg_pkg.sv ====
package eecfg_pkg;

    typedef enum logic [2:0] {
        EECFG_IDLE  = 3'b000,
        EECFG_HDR   = 3'b001,
        EECFG_PTR   = 3'b011,
        EECFG_BLK   = 3'b010,
        EECFG_DONE  = 3'b110
    } eecfg_state_t;

    typedef struct packed {
        logic       crc_enable;
        logic       pointer_table_enable;
        logic       large_eeprom;
        logic [3:0] device_count;
        logic [7:0] eeprom_burst_length;
    } eecfg_header_t;

    typedef struct packed {
        logic       signal_loss_source_select;
        logic       signal_loss_override;
        logic       signal_loss_forced_value;
        logic       input_powerdown;
        logic       oscillator_powerdown;
        logic       sata_mode_channel_a;
        logic       sata_mode_channel_b;
        logic       transmit_disable_override;
        logic [2:0] channel_b_swing_level;
    } eecfg_config_t;

endpackage

// ==== rtl/eecfg_loader.sv ====
// Behaviour
// - header byte 0: crc enable, pointer table, large flag, reserved, count.
// - header byte 2 is burst length; header byte 1 ignored.
// - slot n crc at address 3+2n, block pointer at 4+2n.
// - block byte 4 bits 7..4: loss override, loss value, powerdowns.
// - block byte 4 bits 2..0: sata a, sata b, tx disable; bit 3 ignored.
// - byte 0x18 bits 5..3 become channel b swing, register 0x2D bits 4..2.
// - a block spans offsets 3 to 39, thirty-seven bytes.
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "eecfg_defines.svh"

module eecfg_loader
    import eecfg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // eeprom byte read port
    output logic             ee_req,
    output logic      [7:0]  ee_addr,
    input  wire logic        ee_ack,
    input  wire logic [7:0]  ee_data,
    // loaded configuration
    output eecfg_config_t    cfg,
    output logic             cfg_done
);

    //------------------------------------------------------------
    // state and captured fields
    //------------------------------------------------------------
    // sequencer state, header image and fetch addressing
    eecfg_state_t  state_reg;
    eecfg_header_t hdr_reg;
    logic [7:0]    addr_reg;
    logic [7:0]    base_reg;
    logic [7:0]    ofs_reg;
    logic [1:0]    slot_reg;
    // wishbone side controls and handshake decode
    logic          start_pulse;
    logic          busy_ack;
    logic          acc;

    // a request is taken once; the ack cycle is not a second take
    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    //------------------------------------------------------------
    // eeprom fetch sequencer
    //------------------------------------------------------------
    // byte request stands in every fetch state; address moves on ack only
    assign ee_req  = (state_reg != EECFG_IDLE) && (state_reg != EECFG_DONE);
    assign ee_addr = addr_reg;
    assign busy_ack = ee_req & ee_ack;

    // walk header, own pointer, then block
    // header bytes 0 to 2 are always read so the burst length is held,
    // while only the own slot pointer is fetched afterwards
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= EECFG_IDLE;
            addr_reg  <= 8'h00;
            base_reg  <= 8'h00;
            ofs_reg   <= 8'h00;
        end else begin
            unique case (state_reg)
                EECFG_IDLE, EECFG_DONE: begin
                    if (start_pulse) begin
                        state_reg <= EECFG_HDR;
                        addr_reg  <= `EECFG_HDR_ADDR;
                    end
                end
                EECFG_HDR: begin
                    if (busy_ack) begin
                        if (addr_reg == `EECFG_BURST_ADDR) begin
                            state_reg <= EECFG_PTR;
                            // pointer of own slot
                            addr_reg  <= `EECFG_SLOT_BASE + 8'h01
                                         + {5'h00, slot_reg, 1'b0};
                        end else begin
                            addr_reg <= addr_reg + 8'h01;
                        end
                    end
                end
                EECFG_PTR: begin
                    if (busy_ack) begin
                        state_reg <= EECFG_BLK;
                        // shared pointers need no special case
                        base_reg  <= ee_data;
                        addr_reg  <= ee_data;
                        ofs_reg   <= 8'h00;
                    end
                end
                EECFG_BLK: begin
                    if (busy_ack) begin
                        // last byte index is one below the block length
                        if (ofs_reg == `EECFG_BLK_LEN - 8'h01) begin
                            state_reg <= EECFG_DONE;
                        end else begin
                            ofs_reg  <= ofs_reg + 8'h01;
                            addr_reg <= base_reg + ofs_reg + 8'h01;
                        end
                    end
                end
                default: state_reg <= EECFG_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------
    // header capture
    //------------------------------------------------------------
    // byte 1 is reserved and never reaches the header image
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hdr_reg <= '0;
        end else if (busy_ack && state_reg == EECFG_HDR) begin
            if (addr_reg == `EECFG_HDR_ADDR) begin
                hdr_reg.crc_enable <= ee_data[`EECFG_HDR_CRC_BIT];
                hdr_reg.pointer_table_enable
                    <= ee_data[`EECFG_HDR_MAP_BIT];
                hdr_reg.large_eeprom <= ee_data[`EECFG_HDR_LARGE_BIT];
                hdr_reg.device_count
                    <= ee_data[`EECFG_HDR_CNT_MSB:0];
            end
            if (addr_reg == `EECFG_BURST_ADDR) begin
                hdr_reg.eeprom_burst_length <= ee_data;
            end
        end
    end

    //------------------------------------------------------------
    // block byte mapping
    //------------------------------------------------------------
    // only bytes with mapped fields are decoded; every other block
    // byte is fetched and dropped, so the byte count stays fixed
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // swing comes up as the unloaded default byte gives it
            cfg <= '0;
            cfg.channel_b_swing_level <= `EECFG_SWING_RST;
        end else if (busy_ack && state_reg == EECFG_BLK) begin
            if (ofs_reg == `EECFG_BLK_LOS_OFS) begin
                cfg.signal_loss_source_select
                    <= ee_data[`EECFG_LOS_SEL_BIT];
            end
            if (ofs_reg == `EECFG_BLK_CTL_OFS) begin
                cfg.signal_loss_override
                    <= ee_data[`EECFG_SIGNAL_LOSS_OVERRIDE_BIT];
                cfg.signal_loss_forced_value
                    <= ee_data[`EECFG_LOS_VAL_BIT];
                cfg.input_powerdown <= ee_data[`EECFG_INPUT_POWERDOWN_BIT];
                cfg.oscillator_powerdown
                    <= ee_data[`EECFG_OSCILLATOR_POWERDOWN_BIT];
                cfg.sata_mode_channel_a <= ee_data[`EECFG_SATA_A_BIT];
                cfg.sata_mode_channel_b <= ee_data[`EECFG_SATA_B_BIT];
                cfg.transmit_disable_override
                    <= ee_data[`EECFG_TXDIS_BIT];
            end
            if (ofs_reg == `EECFG_BLK_SWING_OFS) begin
                cfg.channel_b_swing_level
                    <= ee_data[`EECFG_SWING_MSB:`EECFG_SWING_LSB];
            end
        end
    end

    // completion flag
    // stays high until the next start, so software may poll it
    assign cfg_done = (state_reg == EECFG_DONE);

    //------------------------------------------------------------
    // wishbone registers
    //------------------------------------------------------------
    // ctrl: bit0 start (self clearing), bits 9:8 slot
    // slot is frozen while a fetch runs, so the pointer address cannot
    // change between the header reads and the pointer read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            start_pulse <= 1'b0;
            slot_reg    <= 2'h0;
        end else begin
            start_pulse <= 1'b0;
            if (acc && wb_we_i && wb_adr_i == `EECFG_REG_CTRL) begin
                if (wb_sel_i[0]) begin
                    start_pulse <= wb_dat_i[0];
                end
                if (wb_sel_i[1] && !ee_req) begin
                    slot_reg <= wb_dat_i[9:8];
                end
            end
        end
    end

    // ack one cycle after strobe, read data registered
    // data is zero outside the ack cycle so a shared or-mux stays clean
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= 32'h0000_0000;
            if (acc && !wb_we_i) begin
                unique case (wb_adr_i)
                    `EECFG_REG_CTRL:   wb_dat_o <= {22'h0, slot_reg, 8'h00};
                    `EECFG_REG_STATUS: wb_dat_o <= {29'h0, state_reg};
                    `EECFG_REG_HEADER: wb_dat_o <= {17'h0, hdr_reg};
                    `EECFG_REG_CONFIG: wb_dat_o <= {20'h0, cfg_done, cfg};
                    `EECFG_REG_DATA:   wb_dat_o <= {24'h0, base_reg};
                    `EECFG_REG_SLOT:   wb_dat_o <= {24'h0, ofs_reg};
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // eecfg_loader

// ==== test/eecfg_ee_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// serial configuration store, byte reader on the loader clock
// ---------------------------------------------------------------
module eecfg_ee_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ee_req,
    input  wire logic [7:0] ee_addr,
    output logic            ee_ack,
    output logic      [7:0] ee_data
);
    logic [7:0] mem [256];
    int         lat   = 0;
    int         wt    = 0;
    int         n_ack = 0;
    // answer after lat idle cycles; data line toggles when not answering
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ee_ack  <= 1'b0;
            ee_data <= 8'h00;
            wt      <= 0;
        end else if (ee_req && !ee_ack && wt >= lat) begin
            ee_ack  <= 1'b1;
            ee_data <= mem[ee_addr];
            wt      <= 0;
            n_ack   <= n_ack + 1;
        end else begin
            ee_ack  <= 1'b0;
            ee_data <= ~ee_data;
            wt      <= ee_req ? wt + 1 : 0;
        end
    end
endmodule // eecfg_ee_model

// ==== test/eecfg_loader_chk.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module eecfg_loader_chk (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        ee_req,
    input wire logic [7:0]  ee_addr,
    input wire logic        ee_ack,
    input wire logic        cfg_done
);
    logic [5:0] n_reg;
    logic [7:0] base_reg;
    // bytes taken since the last start, first block address
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) n_reg <= 6'h00;
        else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 &&
                 wb_sel_i[0] && wb_dat_i[0]) n_reg <= 6'h00;
        else if (ee_req && ee_ack) n_reg <= n_reg + 6'h01;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) base_reg <= 8'h00;
        else if (ee_req && n_reg == 6'h04) base_reg <= ee_addr;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_last; ee_req && ee_ack && n_reg == 6'h28; endsequence
    property p_ack_lat; s_take |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_addr_hold;
        ee_req && !ee_ack |=> ee_req && $stable(ee_addr);
    endproperty
    property p_hdr_order;
        ee_req && n_reg < 6'h03 |-> ee_addr == {2'h0, n_reg};
    endproperty
    property p_ptr_addr;
        ee_req && n_reg == 6'h03 |-> ee_addr inside {8'h04, 8'h06, 8'h08, 8'h0A};
    endproperty
    property p_blk_seq;
        ee_req && n_reg > 6'h04 |-> ee_addr == base_reg + 8'(n_reg - 6'h04);
    endproperty
    property p_blk_len; ee_req |-> n_reg < 6'h29; endproperty
    property p_done; s_last |-> ##[1:2] cfg_done && !ee_req; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
    a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
    a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
    a_hdr_order: assert property (p_hdr_order) else $error("hdr order");
    a_ptr_addr: assert property (p_ptr_addr) else $error("bad slot");
    a_blk_seq: assert property (p_blk_seq) else $error("block order");
    a_blk_len: assert property (p_blk_len) else $error("block long");
    a_done: assert property (p_done) else $error("done late");
endmodule // eecfg_loader_chk
bind eecfg_loader eecfg_loader_chk u_chk (.core_clk, .rst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .ee_req, .ee_addr, .ee_ack, .cfg_done);

// ==== test/eecfg_loader_tb_top.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// loader bench
// ---------------------------------------------------------------
module eecfg_loader_tb_top;
    import eecfg_pkg::*;
    logic          core_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0;
    logic          wb_we_i = 0, wb_ack_o, ee_req, ee_ack, cfg_done;
    logic [7:0]    wb_adr_i = 8'h00, ee_addr, ee_data;
    logic [3:0]    wb_sel_i = 4'hF;
    logic [31:0]   wb_dat_i = 32'h0, wb_dat_o, q;
    eecfg_config_t cfg;
    int            num_errors = 0, check_count = 0, cyc = 0, s, i;
    logic [7:0]    ptr_tab [4] = '{8'h0B, 8'h30, 8'h30, 8'h0B};
    always #2.5 core_clk = ~core_clk;
    eecfg_loader u_dut (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ee_req,
        .ee_addr, .ee_ack, .ee_data, .cfg, .cfg_done);
    eecfg_ee_model u_ee (.core_clk, .rst, .ee_req, .ee_addr, .ee_ack,
        .ee_data);
    task complete_run;
        if (num_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask
    // expected settings of the block at p
    function automatic logic [10:0] ex(input logic [7:0] p);
        return {u_ee.mem[p][2], u_ee.mem[p+1][7:4], u_ee.mem[p+1][2:0],
                u_ee.mem[p+8'h15][5:3]};
    endfunction
    always @(posedge core_clk) if (++cyc == 20000) begin
        num_errors++;
        complete_run;
    end
    initial begin
        for (i = 0; i < 256; i++) u_ee.mem[i] = 8'(i * 13 + 1);
        u_ee.mem[0] = 8'hF3;
        u_ee.mem[1] = 8'hFF;
        u_ee.mem[2] = 8'h08;
        for (s = 0; s < 4; s++) u_ee.mem[4+2*s] = ptr_tab[s];
        u_ee.mem[11] = 8'h04;
        u_ee.mem[12] = 8'hA5;
        u_ee.mem[32] = 8'hE7;
        u_ee.mem[48] = 8'hFB;
        u_ee.mem[49] = 8'h5A;
        u_ee.mem[69] = 8'h5A;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        wb(0, 8'h0C, 0); chk(q, 32'h3);
        wb(1, 8'hF8, 32'hFFFF);
        wb(0, 8'hF8, 0); chk(q, 32'h0);
        for (s = 0; s < 4; s++) begin
            u_ee.lat <= s * 3;
            i = u_ee.n_ack;
            wb(1, 8'h00, {22'h0, 2'(s), 8'h01});
            wb(1, 8'h00, {22'h0, ~2'(s), 8'h00});
            do @(posedge core_clk); while (cfg_done !== 1'b1);
            chk({21'h0, cfg}, {21'h0, ex(ptr_tab[s])});
            chk(32'(u_ee.n_ack - i), 32'd41);
            wb(0, 8'h08, 0); chk(q, 32'h7308);
            wb(0, 8'h10, 0); chk(q, {24'h0, ptr_tab[s]});
            wb(0, 8'h0C, 0); chk(q, {20'h0, 1'b1, ex(ptr_tab[s])});
            wb(0, 8'h04, 0); chk(q, 32'h6);
            wb(0, 8'h00, 0);
            chk(q, {22'h0, 2'(s), 8'h00});
            wb(0, 8'h14, 0);
            chk(q, 32'h24);
        end
        complete_run;
    end
endmodule // eecfg_loader_tb_top
